// File: core/aarc_consts.svh
`ifndef AARC_CONSTS_SVH
`define AARC_CONSTS_SVH

// Register indices; byte address is four times the index
`define AARC_IDX_RX_SAFE      8'h0c
`define AARC_IDX_RX_CTRL      8'h17
`define AARC_IDX_SLOT_CTRL    8'h2c
`define AARC_IDX_ROLE_CTRL    8'h2e
`define AARC_IDX_SHORT_LO     8'h20
`define AARC_IDX_SHORT_HI     8'h21
`define AARC_IDX_NETID_LO     8'h22
`define AARC_IDX_NETID_HI     8'h23
`define AARC_IDX_EXT_B0       8'h24
`define AARC_IDX_EXT_B7       8'h2b
`define AARC_IDX_EXT_FEAT     8'h30
`define AARC_IDX_ALT_SFD      8'h31
`define AARC_IDX_STATUS       8'h32

// Writable bit masks; other bits read as zero
`define AARC_MASK_RX_SAFE     8'h80
`define AARC_MASK_RX_CTRL     8'h36
`define AARC_MASK_SLOT_CTRL   8'h01
`define AARC_MASK_ROLE_CTRL   8'hf8
`define AARC_MASK_EXT_FEAT    8'hf1

// Field positions
`define AARC_BIT_SAFE         7
`define AARC_BIT_PROMISC      1
`define AARC_BIT_ACK_TIME     2
`define AARC_BIT_RES_RX       4
`define AARC_BIT_RES_FILT     5
`define AARC_BIT_SLOTTED      0
`define AARC_BIT_COORD        3
`define AARC_BIT_ACK_SUPP     4
`define AARC_BIT_PEND         5
`define AARC_FLD_VER_HI       7
`define AARC_FLD_VER_LO       6
`define AARC_BIT_ANTENNA_DIVERSITY      0
`define AARC_FLD_PDT_HI       7
`define AARC_FLD_PDT_LO       4

// Reset values
`define AARC_RST_RX_SAFE      8'h00
`define AARC_RST_RX_CTRL      8'h00
`define AARC_RST_SLOT_CTRL    8'h00
`define AARC_RST_ROLE_CTRL    8'h40
`define AARC_RST_SHORT        16'hffff
`define AARC_RST_NETID        16'hffff
`define AARC_RST_EXT          64'h0000_0000_0000_0000
`define AARC_RST_EXT_FEAT     8'h00
`define AARC_RST_ALT_SFD      8'h00

// Frame fields
`define AARC_FT_BEACON        3'h0
`define AARC_FT_DATA          3'h1
`define AARC_FT_CMD           3'h3
`define AARC_AM_NONE          2'h0
`define AARC_AM_SHORT         2'h2
`define AARC_AM_EXT           2'h3
`define AARC_BCAST            16'hffff

// Timing
`define AARC_CLK_NS           100
`define AARC_SYMBOL_NS        16000
`define AARC_TURN_LONG_SYM    12
`define AARC_TURN_SHORT_SYM   2
`define AARC_TURN_LONG_CYC  ((`AARC_TURN_LONG_SYM * `AARC_SYMBOL_NS + `AARC_CLK_NS - 1) / `AARC_CLK_NS)
`define AARC_TURN_SHORT_CYC ((`AARC_TURN_SHORT_SYM * `AARC_SYMBOL_NS + `AARC_CLK_NS - 1) / `AARC_CLK_NS)
`define AARC_TCNT_W           11

// Bus answers
`define AARC_RESP_OKAY        2'h0
`define AARC_RESP_SLVERR      2'h2

`endif

// File: core/aarc_pkg.sv
package aarc_pkg;

	typedef enum logic [2:0] {
		AARC_IDLE = 3'b001,
		AARC_TURN = 3'b010,
		AARC_SLOT = 3'b100
	} aarc_state_t;

	// Parsed header of a received frame, valid with the frame end strobe
	typedef struct packed {
		logic        fcs_ok;
		logic [2:0]  frame_type;
		logic        ack_req;
		logic [1:0]  version;
		logic [1:0]  dst_mode;
		logic [1:0]  src_mode;
		logic [15:0] dst_pan;
		logic [15:0] src_pan;
		logic [15:0] dst_short;
		logic [63:0] dst_ext;
		logic        data_req;
		logic [7:0]  seq;
	} aarc_rx_hdr_t;

	typedef struct packed {
		logic [15:0] short_addr;
		logic [15:0] network_id;
		logic [63:0] ext_addr;
		logic        promiscuous_support;
		logic        reserved_type_receive_enable;
		logic        reserved_type_filter_enable;
		logic        coordinator_role;
		logic [1:0]  frame_version_select;
	} aarc_cfg_t;

	typedef struct packed {
		logic [7:0] seq;
		logic       frame_pending;
	} aarc_ack_t;

endpackage

// File: core/aarc_filter.sv
`timescale 1ns/1ps
`include "aarc_consts.svh"

module aarc_filter
	import aarc_pkg::*;
(
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire aarc_rx_hdr_t hdr,
	input  wire aarc_cfg_t    cfg,
	output logic              accept,
	output logic              ack_ok
);

	logic pan_ok;
	logic dst_ok;
	logic is_dc;
	logic is_res;
	logic third_ok;
	logic ver_ok;

	always_comb begin
		is_dc  = (hdr.frame_type == `AARC_FT_DATA) ||
		         (hdr.frame_type == `AARC_FT_CMD);
		is_res = hdr.frame_type[2];
		pan_ok = (hdr.dst_pan == cfg.network_id) ||
		         (hdr.dst_pan == `AARC_BCAST);
		unique case (hdr.dst_mode)
			`AARC_AM_SHORT: begin
				dst_ok = pan_ok &&
				         ((hdr.dst_short == cfg.short_addr) ||
				          (hdr.dst_short == `AARC_BCAST));
			end
			`AARC_AM_EXT: begin
				dst_ok = pan_ok && (hdr.dst_ext == cfg.ext_addr);
			end
			`AARC_AM_NONE: begin
				dst_ok = cfg.coordinator_role &&
				         (hdr.src_mode != `AARC_AM_NONE) &&
				         (hdr.src_pan == cfg.network_id);
			end
			default: begin
				dst_ok = 1'b0;
			end
		endcase
		if (hdr.frame_type == `AARC_FT_BEACON) begin
			third_ok = (cfg.network_id == `AARC_BCAST) ||
			           (hdr.src_pan == cfg.network_id);
		end else if (is_dc || (is_res && cfg.reserved_type_filter_enable)) begin
			third_ok = dst_ok;
		end else begin
			third_ok = is_res;
		end
		ver_ok = (hdr.version <= cfg.frame_version_select);
		if (cfg.promiscuous_support) begin
			accept = hdr.fcs_ok;
		end else begin
			accept = hdr.fcs_ok && third_ok &&
			         (!is_res || cfg.reserved_type_receive_enable);
		end
		ack_ok = accept && !cfg.promiscuous_support && hdr.ack_req &&
		         is_dc && ver_ok;
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_res_reject: assert property (
		hdr.frame_type[2] && !cfg.reserved_type_receive_enable &&
		!cfg.promiscuous_support |-> !accept)
		else $error("reserved frame type accepted while disabled");
	a_null_dst: assert property (
		(hdr.dst_mode == `AARC_AM_NONE) && !cfg.coordinator_role &&
		is_dc && !cfg.promiscuous_support |-> !accept)
		else $error("frame without destination accepted by non-coordinator");

endmodule

// File: core/aarc_ack_timer.sv
`timescale 1ns/1ps
`include "aarc_consts.svh"

module aarc_ack_timer (
	input  wire logic                    aclk,
	input  wire logic                    aresetn,
	input  wire logic                    start,
	input  wire logic [`AARC_TCNT_W-1:0] load,
	input  wire logic                    cancel,
	output logic                         done
);

	logic [`AARC_TCNT_W-1:0] cnt_reg;
	logic                    run_reg;

	assign done = run_reg && (cnt_reg == `AARC_TCNT_W'(1));

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_reg <= '0;
			run_reg <= 1'b0;
		end else if (start) begin
			cnt_reg <= load;
			run_reg <= 1'b1;
		end else if (cancel || done) begin
			run_reg <= 1'b0;
		end else if (run_reg) begin
			cnt_reg <= cnt_reg - `AARC_TCNT_W'(1);
		end
	end

endmodule

// File: core/aarc_top.sv
`timescale 1ns/1ps
`include "aarc_consts.svh"

module aarc_top
	import aarc_pkg::*;
(
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic [7:0]   s_axi_awaddr,
	input  wire logic         s_axi_awvalid,
	output logic              s_axi_awready,
	input  wire logic [31:0]  s_axi_wdata,
	input  wire logic [3:0]   s_axi_wstrb,
	input  wire logic         s_axi_wvalid,
	output logic              s_axi_wready,
	output logic [1:0]        s_axi_bresp,
	output logic              s_axi_bvalid,
	input  wire logic         s_axi_bready,
	input  wire logic [7:0]   s_axi_araddr,
	input  wire logic         s_axi_arvalid,
	output logic              s_axi_arready,
	output logic [31:0]       s_axi_rdata,
	output logic [1:0]        s_axi_rresp,
	output logic              s_axi_rvalid,
	input  wire logic         s_axi_rready,
	input  wire aarc_rx_hdr_t rx_hdr,
	input  wire logic         rx_frame_end,
	input  wire logic         rx_buffer_release,
	input  wire logic         sleep_transmit_trigger_pin,
	output logic              rx_frame_store,
	output logic              rx_buffer_locked,
	output logic              ack_tx_start,
	output aarc_ack_t         ack_tx,
	output logic [7:0]        alt_frame_delimiter,
	output logic              antenna_diversity,
	output logic [3:0]        rx_power_detect_threshold
);

	function automatic logic [7:0] byte_index(input logic [7:0] addr);
		byte_index = {2'h0, addr[7:2]};
	endfunction

	function automatic logic idx_mapped(input logic [7:0] idx);
		idx_mapped = (idx == `AARC_IDX_RX_SAFE) ||
		             (idx == `AARC_IDX_RX_CTRL) ||
		             (idx == `AARC_IDX_SLOT_CTRL) ||
		             (idx == `AARC_IDX_ROLE_CTRL) ||
		             ((idx >= `AARC_IDX_SHORT_LO) &&
		              (idx <= `AARC_IDX_EXT_B7)) ||
		             ((idx >= `AARC_IDX_EXT_FEAT) &&
		              (idx <= `AARC_IDX_STATUS));
	endfunction

	// Bit offset of an extended address byte, byte 0 at the bottom
	function automatic logic [5:0] ext_lsb(input logic [7:0] idx);
		logic [7:0] off;
		off     = idx - `AARC_IDX_EXT_B0;
		ext_lsb = {off[2:0], 3'h0};
	endfunction

	// Register storage
	logic [7:0]  safe_reg;
	logic [7:0]  rx_ctrl_reg;
	logic [7:0]  slot_ctrl_reg;
	logic [7:0]  role_ctrl_reg;
	logic [15:0] short_addr_reg;
	logic [15:0] network_id_reg;
	logic [63:0] ext_addr_reg;
	logic [7:0]  ext_feat_reg;
	logic [7:0]  alt_sfd_reg;

	// Bus slave state
	logic        aw_full_reg;
	logic        w_full_reg;
	logic [7:0]  aw_idx_reg;
	logic [7:0]  w_data_reg;
	logic        w_strb_reg;
	logic        bvalid_reg;
	logic [1:0]  bresp_reg;
	logic        rvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0]  rresp_reg;
	logic        wr_en;
	logic [7:0]  ar_idx;
	logic [7:0]  rd_next;

	// Receive and acknowledge state
	aarc_state_t state_reg;
	aarc_state_t state_next;
	aarc_cfg_t   cfg;
	aarc_ack_t   ack_next;
	aarc_ack_t   ack_reg;
	logic        ack_start_reg;
	logic        store_reg;
	logic        locked_reg;
	logic        trig_prev_reg;
	logic        trig_rise;
	logic        accept;
	logic        ack_ok;
	logic        ack_go;
	logic        timer_done;
	logic        slotted_lat_reg;
	logic        short_lat_reg;
	logic [`AARC_TCNT_W-1:0] turn_load;
	logic [11:0] since_end_reg;

	assign s_axi_awready = !aw_full_reg && !bvalid_reg;
	assign s_axi_wready  = !w_full_reg && !bvalid_reg;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;
	assign s_axi_arready = !rvalid_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rdata   = rdata_reg;
	assign s_axi_rresp   = rresp_reg;
	assign wr_en         = aw_full_reg && w_full_reg && !bvalid_reg;
	assign ar_idx        = byte_index(s_axi_araddr);

	// Write address and data are taken in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_reg <= 1'b0;
			aw_idx_reg  <= 8'h00;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_full_reg <= 1'b1;
			aw_idx_reg  <= byte_index(s_axi_awaddr);
		end else if (wr_en) begin
			aw_full_reg <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_full_reg <= 1'b0;
			w_data_reg <= 8'h00;
			w_strb_reg <= 1'b0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_full_reg <= 1'b1;
			w_data_reg <= s_axi_wdata[7:0];
			w_strb_reg <= s_axi_wstrb[0];
		end else if (wr_en) begin
			w_full_reg <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_reg <= 1'b0;
			bresp_reg  <= `AARC_RESP_OKAY;
		end else if (wr_en) begin
			bvalid_reg <= 1'b1;
			bresp_reg  <= idx_mapped(aw_idx_reg) ? `AARC_RESP_OKAY
			                                     : `AARC_RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_reg <= 1'b0;
		end
	end

	// Configuration writes; status register is read only
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			safe_reg       <= `AARC_RST_RX_SAFE;
			rx_ctrl_reg    <= `AARC_RST_RX_CTRL;
			slot_ctrl_reg  <= `AARC_RST_SLOT_CTRL;
			role_ctrl_reg  <= `AARC_RST_ROLE_CTRL;
			short_addr_reg <= `AARC_RST_SHORT;
			network_id_reg <= `AARC_RST_NETID;
			ext_addr_reg   <= `AARC_RST_EXT;
			ext_feat_reg   <= `AARC_RST_EXT_FEAT;
			alt_sfd_reg    <= `AARC_RST_ALT_SFD;
		end else if (wr_en && w_strb_reg) begin
			unique case (aw_idx_reg)
				`AARC_IDX_RX_SAFE:
					safe_reg <= w_data_reg & `AARC_MASK_RX_SAFE;
				`AARC_IDX_RX_CTRL:
					rx_ctrl_reg <= w_data_reg & `AARC_MASK_RX_CTRL;
				`AARC_IDX_SLOT_CTRL:
					slot_ctrl_reg <= w_data_reg & `AARC_MASK_SLOT_CTRL;
				`AARC_IDX_ROLE_CTRL:
					role_ctrl_reg <= w_data_reg & `AARC_MASK_ROLE_CTRL;
				`AARC_IDX_SHORT_LO: short_addr_reg[7:0]  <= w_data_reg;
				`AARC_IDX_SHORT_HI: short_addr_reg[15:8] <= w_data_reg;
				`AARC_IDX_NETID_LO: network_id_reg[7:0]  <= w_data_reg;
				`AARC_IDX_NETID_HI: network_id_reg[15:8] <= w_data_reg;
				`AARC_IDX_EXT_FEAT:
					ext_feat_reg <= w_data_reg & `AARC_MASK_EXT_FEAT;
				`AARC_IDX_ALT_SFD: alt_sfd_reg <= w_data_reg;
				default: begin
					if ((aw_idx_reg >= `AARC_IDX_EXT_B0) &&
					    (aw_idx_reg <= `AARC_IDX_EXT_B7)) begin
						ext_addr_reg[ext_lsb(aw_idx_reg) +: 8]
							<= w_data_reg;
					end
				end
			endcase
		end
	end

	always_comb begin
		rd_next = 8'h00;
		unique case (ar_idx)
			`AARC_IDX_RX_SAFE:   rd_next = safe_reg;
			`AARC_IDX_RX_CTRL:   rd_next = rx_ctrl_reg;
			`AARC_IDX_SLOT_CTRL: rd_next = slot_ctrl_reg;
			`AARC_IDX_ROLE_CTRL: rd_next = role_ctrl_reg;
			`AARC_IDX_SHORT_LO:  rd_next = short_addr_reg[7:0];
			`AARC_IDX_SHORT_HI:  rd_next = short_addr_reg[15:8];
			`AARC_IDX_NETID_LO:  rd_next = network_id_reg[7:0];
			`AARC_IDX_NETID_HI:  rd_next = network_id_reg[15:8];
			`AARC_IDX_EXT_FEAT:  rd_next = ext_feat_reg;
			`AARC_IDX_ALT_SFD:   rd_next = alt_sfd_reg;
			`AARC_IDX_STATUS:    rd_next = {4'h0, locked_reg, state_reg};
			default: begin
				if ((ar_idx >= `AARC_IDX_EXT_B0) &&
				    (ar_idx <= `AARC_IDX_EXT_B7)) begin
					rd_next = ext_addr_reg[ext_lsb(ar_idx) +: 8];
				end
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_reg <= 1'b0;
			rdata_reg  <= 32'h0000_0000;
			rresp_reg  <= `AARC_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_reg <= 1'b1;
			rdata_reg  <= {24'h00_0000, rd_next};
			rresp_reg  <= idx_mapped(ar_idx) ? `AARC_RESP_OKAY
			                                 : `AARC_RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end
	end

	// Side settings stay independent of the receive mode
	assign alt_frame_delimiter       = alt_sfd_reg;
	assign antenna_diversity         = ext_feat_reg[`AARC_BIT_ANTENNA_DIVERSITY];
	assign rx_power_detect_threshold =
		ext_feat_reg[`AARC_FLD_PDT_HI:`AARC_FLD_PDT_LO];

	always_comb begin
		cfg.short_addr                   = short_addr_reg;
		cfg.network_id                   = network_id_reg;
		cfg.ext_addr                     = ext_addr_reg;
		cfg.promiscuous_support          = rx_ctrl_reg[`AARC_BIT_PROMISC];
		cfg.reserved_type_receive_enable = rx_ctrl_reg[`AARC_BIT_RES_RX];
		cfg.reserved_type_filter_enable  = rx_ctrl_reg[`AARC_BIT_RES_FILT];
		cfg.coordinator_role             = role_ctrl_reg[`AARC_BIT_COORD];
		cfg.frame_version_select         =
			role_ctrl_reg[`AARC_FLD_VER_HI:`AARC_FLD_VER_LO];
	end

	aarc_filter u_filter (
		.aclk    (aclk),
		.aresetn (aresetn),
		.hdr     (rx_hdr),
		.cfg     (cfg),
		.accept  (accept),
		.ack_ok  (ack_ok)
	);

	// Ack is taken only while idle and not suppressed
	assign ack_go = rx_frame_end && ack_ok && (state_reg == AARC_IDLE) &&
	                !role_ctrl_reg[`AARC_BIT_ACK_SUPP];
	assign turn_load = rx_ctrl_reg[`AARC_BIT_ACK_TIME] ?
		`AARC_TCNT_W'(`AARC_TURN_SHORT_CYC) :
		`AARC_TCNT_W'(`AARC_TURN_LONG_CYC);
	assign trig_rise = sleep_transmit_trigger_pin && !trig_prev_reg;

	aarc_ack_timer u_timer (
		.aclk    (aclk),
		.aresetn (aresetn),
		.start   (ack_go),
		.load    (turn_load),
		.cancel  (1'b0),
		.done    (timer_done)
	);

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			AARC_IDLE: if (ack_go) state_next = AARC_TURN;
			AARC_TURN: begin
				if (timer_done) begin
					state_next = slotted_lat_reg ? AARC_SLOT : AARC_IDLE;
				end
			end
			AARC_SLOT: if (trig_rise) state_next = AARC_IDLE;
			default: state_next = AARC_IDLE;
		endcase
	end

	always_comb begin
		ack_next.seq           = rx_hdr.seq;
		ack_next.frame_pending = rx_hdr.data_req &&
		                         role_ctrl_reg[`AARC_BIT_PEND];
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg       <= AARC_IDLE;
			trig_prev_reg   <= 1'b0;
			slotted_lat_reg <= 1'b0;
			short_lat_reg   <= 1'b0;
			ack_reg         <= '0;
		end else begin
			state_reg     <= state_next;
			trig_prev_reg <= sleep_transmit_trigger_pin;
			if (ack_go) begin
				slotted_lat_reg <= slot_ctrl_reg[`AARC_BIT_SLOTTED];
				short_lat_reg   <= rx_ctrl_reg[`AARC_BIT_ACK_TIME];
				ack_reg         <= ack_next;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ack_start_reg <= 1'b0;
		end else begin
			ack_start_reg <= ((state_reg == AARC_TURN) && timer_done &&
			                  !slotted_lat_reg) ||
			                 ((state_reg == AARC_SLOT) && trig_rise);
		end
	end

	assign ack_tx_start = ack_start_reg;
	assign ack_tx       = ack_reg;

	// Accepted frames stored only while the buffer is free; set beats release
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			store_reg  <= 1'b0;
			locked_reg <= 1'b0;
		end else begin
			store_reg <= rx_frame_end && accept && !locked_reg;
			if (rx_frame_end && accept && !locked_reg &&
			    safe_reg[`AARC_BIT_SAFE]) begin
				locked_reg <= 1'b1;
			end else if (rx_buffer_release) begin
				locked_reg <= 1'b0;
			end
		end
	end

	assign rx_frame_store   = store_reg;
	assign rx_buffer_locked = locked_reg;

	// Cycles since the frame end that started the current ack
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			since_end_reg <= 12'h000;
		end else if (ack_go) begin
			since_end_reg <= 12'h001;
		end else if (since_end_reg != 12'hfff) begin
			since_end_reg <= since_end_reg + 12'h001;
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_ack_long_time: assert property (
		ack_start_reg && !slotted_lat_reg && !short_lat_reg |->
		since_end_reg == 12'(`AARC_TURN_LONG_CYC + 1))
		else $error("long turnaround ack at wrong cycle");
	a_ack_short_time: assert property (
		ack_start_reg && !slotted_lat_reg && short_lat_reg |->
		since_end_reg == 12'(`AARC_TURN_SHORT_CYC + 1))
		else $error("short turnaround ack at wrong cycle");
	a_no_prom_ack: assert property (
		rx_frame_end && rx_ctrl_reg[`AARC_BIT_PROMISC] &&
		state_reg == AARC_IDLE |=> state_reg == AARC_IDLE)
		else $error("ack started in promiscuous mode");
	a_ack_suppress: assert property (
		rx_frame_end && role_ctrl_reg[`AARC_BIT_ACK_SUPP] &&
		state_reg == AARC_IDLE |=> !ack_tx_start [*2])
		else $error("ack started while suppressed");
	a_slot_hold: assert property (
		state_reg == AARC_SLOT && !trig_rise |=> !ack_tx_start)
		else $error("slotted ack sent without trigger");
	a_slot_go: assert property (
		state_reg == AARC_SLOT && trig_rise |=> ack_tx_start &&
		state_reg == AARC_IDLE)
		else $error("slotted ack not sent on trigger");
	a_pend_zero: assert property (
		ack_go && !rx_hdr.data_req |=> ack_tx.frame_pending == 1'b0)
		else $error("pending set for non data request ack");
	a_pend_set: assert property (
		ack_go && rx_hdr.data_req && role_ctrl_reg[`AARC_BIT_PEND] |=>
		ack_tx.frame_pending && ack_tx.seq == $past(rx_hdr.seq))
		else $error("pending value not carried into ack");
	a_safe_lock: assert property (
		rx_frame_end && accept && !locked_reg && safe_reg[`AARC_BIT_SAFE]
		|=> locked_reg && rx_frame_store)
		else $error("buffer not locked after protected frame");
	a_short_reset: assert property (
		!$past(aresetn) |-> short_addr_reg == `AARC_RST_SHORT &&
		role_ctrl_reg == `AARC_RST_ROLE_CTRL)
		else $error("address or version select reset wrong");

	c_ack_sent: cover property (ack_go ##[1:1000] ack_tx_start);
	c_slot_ack: cover property (state_reg == AARC_SLOT ##1 ack_tx_start);
	c_locked:   cover property (rx_buffer_locked && rx_buffer_release);

endmodule

// File: bench/aarc_node_model.sv
`timescale 1ns/1ps
module aarc_node_model
	import aarc_pkg::*;
(
	input  wire logic         aclk,
	input  wire logic         send,
	input  wire aarc_rx_hdr_t hdr_in,
	output aarc_rx_hdr_t      rx_hdr,
	output logic              rx_frame_end
);
	initial rx_frame_end = 1'b0;
	initial rx_hdr = '0;
	// Header lines scramble outside the end strobe
	always @(posedge aclk) begin
		rx_frame_end <= send;
		rx_hdr       <= send ? hdr_in : ~rx_hdr;
	end
endmodule

// File: bench/aarc_tb_top.sv
`timescale 1ns/1ps
`include "aarc_consts.svh"
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin \
	err_count++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module aarc_tb_top import aarc_pkg::*;;
	logic         aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic         send, rel, pin, awready, wready, bvalid, arready, rvalid;
	logic         fend, store, locked, ack_go, ant, st;
	logic [7:0]   awaddr, araddr, sfd;
	logic [31:0]  wdata, rdata;
	logic [1:0]   bresp, rresp;
	logic [3:0]   pdt;
	aarc_rx_hdr_t h, rxh;
	aarc_ack_t    ack;
	int           err_count, check_count;
	always #50 aclk = ~aclk;
	aarc_node_model node (.aclk(aclk), .send(send), .hdr_in(h),
		.rx_hdr(rxh), .rx_frame_end(fend));
	aarc_top uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .rx_hdr(rxh), .rx_frame_end(fend),
		.rx_buffer_release(rel), .sleep_transmit_trigger_pin(pin),
		.rx_frame_store(store), .rx_buffer_locked(locked),
		.ack_tx_start(ack_go), .ack_tx(ack), .alt_frame_delimiter(sfd),
		.antenna_diversity(ant), .rx_power_detect_threshold(pdt));
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic hang;
		err_count++;
		$display("mismatch bus_wait exp done got timeout");
		tally_and_finish();
	endtask
	task automatic wr(input logic [7:0] i, input logic [7:0] d,
		input logic [1:0] er);
		int n;
		@(posedge aclk);
		awaddr  <= {i[5:0], 2'b00};
		wdata   <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(posedge aclk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
			if (bvalid) begin
				bready <= 1'b0;
				`CHK("bresp", er, bresp)
				break;
			end
		end
		if (n == 40)
			hang();
	endtask
	task automatic rd(input logic [7:0] i, input logic [7:0] e,
		input logic [1:0] er);
		int n;
		@(posedge aclk);
		araddr  <= {i[5:0], 2'b00};
		arvalid <= 1'b1;
		rready  <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(posedge aclk);
			if (arready)
				arvalid <= 1'b0;
			if (rvalid) begin
				rready <= 1'b0;
				`CHK("rdata", {24'h0, e}, rdata)
				`CHK("rresp", er, rresp)
				break;
			end
		end
		if (n == 40)
			hang();
	endtask
	// Cycles from the frame end cycle to the ack start, 0 if none
	task automatic frm(input int ec, input logic ep);
		int k;
		@(posedge aclk);
		send <= 1'b1;
		@(posedge aclk);
		send <= 1'b0;
		for (k = 0; k <= 2000; k++) begin
			@(negedge aclk);
			if (k == 1)
				st = store;
			if (ack_go)
				break;
		end
		`CHK("ack_cycles", ec, (k > 2000) ? 0 : k)
		if (ec != 0) begin
			`CHK("ack_seq", h.seq, ack.seq)
			`CHK("ack_pend", ep, ack.frame_pending)
		end
	endtask
	initial begin
		{aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
		{send, rel, pin, awaddr, araddr, wdata} = '0;
		err_count = 0;
		check_count = 0;
		h = '0;
		h.fcs_ok = 1'b1;
		h.frame_type = `AARC_FT_DATA;
		h.ack_req = 1'b1;
		h.version = 2'h1;
		h.dst_mode = `AARC_AM_SHORT;
		h.src_mode = `AARC_AM_SHORT;
		h.dst_pan = 16'hffff;
		h.dst_short = 16'h1234;
		h.seq = 8'h5a;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rd(8'h2e, 8'h40, 2'h0);
		rd(8'h0c, 8'h00, 2'h0);
		rd(8'h20, 8'hff, 2'h0);
		rd(8'h17, 8'h00, 2'h0);
		rd(8'h3f, 8'h00, 2'h2);
		wr(8'h3f, 8'h11, 2'h2);
		frm(0, 1'b0);
		`CHK("store", 1'b0, st)
		h.dst_mode = `AARC_AM_EXT;
		frm(1921, 1'b0);
		`CHK("locked", 1'b0, locked)
		$display("test reset done");
		wr(8'h20, 8'h34, 2'h0);
		wr(8'h21, 8'h12, 2'h0);
		wr(8'h22, 8'hcd, 2'h0);
		wr(8'h23, 8'hab, 2'h0);
		rd(8'h21, 8'h12, 2'h0);
		h.dst_mode = `AARC_AM_SHORT;
		h.dst_pan = 16'habcd;
		h.src_pan = 16'habcd;
		frm(1921, 1'b0);
		wr(8'h24, 8'h11, 2'h0);
		h.dst_mode = `AARC_AM_EXT;
		h.dst_ext = 64'h11;
		frm(1921, 1'b0);
		h.dst_mode = `AARC_AM_SHORT;
		wr(8'h17, 8'h04, 2'h0);
		frm(321, 1'b0);
		wr(8'h17, 8'h02, 2'h0);
		frm(0, 1'b0);
		`CHK("store", 1'b1, st)
		h.frame_type = 3'h4;
		h.dst_short = 16'h0bad;
		for (int m = 0; m < 4; m++) begin
			wr(8'h17, {2'b00, m[1:0], 4'h0}, 2'h0);
			frm(0, 1'b0);
			`CHK("store", m == 1, st)
		end
		h.dst_short = 16'h1234;
		wr(8'h17, 8'h00, 2'h0);
		$display("test timing done");
		wr(8'h2e, 8'h60, 2'h0);
		h.frame_type = `AARC_FT_CMD;
		h.data_req = 1'b1;
		frm(1921, 1'b1);
		h.data_req = 1'b0;
		frm(1921, 1'b0);
		h.frame_type = `AARC_FT_DATA;
		wr(8'h2e, 8'h50, 2'h0);
		frm(0, 1'b0);
		for (int s = 0; s < 4; s++)
			for (int v = 0; v < 4; v++) begin
				wr(8'h2e, {s[1:0], 6'h00}, 2'h0);
				h.version = v[1:0];
				frm((v <= s) ? 1921 : 0, 1'b0);
			end
		h.version = 2'h1;
		h.dst_mode = `AARC_AM_NONE;
		wr(8'h2e, 8'h48, 2'h0);
		frm(1921, 1'b0);
		wr(8'h2e, 8'h40, 2'h0);
		frm(0, 1'b0);
		h.dst_mode = `AARC_AM_SHORT;
		$display("test ack fields done");
		wr(8'h2c, 8'h01, 2'h0);
		frm(0, 1'b0);
		rd(8'h32, 8'h04, 2'h0);
		@(posedge aclk);
		pin <= 1'b1;
		@(posedge aclk);
		pin <= 1'b0;
		@(negedge aclk);
		`CHK("slot_ack", 1'b1, ack_go)
		wr(8'h2c, 8'h00, 2'h0);
		wr(8'h0c, 8'h80, 2'h0);
		frm(1921, 1'b0);
		`CHK("locked", 1'b1, locked)
		`CHK("store", 1'b1, st)
		frm(1921, 1'b0);
		`CHK("store", 1'b0, st)
		@(posedge aclk);
		rel <= 1'b1;
		@(posedge aclk);
		rel <= 1'b0;
		@(negedge aclk);
		`CHK("locked", 1'b0, locked)
		wr(8'h30, 8'ha1, 2'h0);
		wr(8'h31, 8'h5c, 2'h0);
		`CHK("ant", 1'b1, ant)
		`CHK("pdt", 4'ha, pdt)
		`CHK("sfd", 8'h5c, sfd)
		$display("test slot and protect done");
		tally_and_finish();
	end
endmodule
